// ### rtl/uessb_pkg.sv
// Purpose: constants and carrier types for the endpoint stall and bus status block
// Assumes: avalon-mm slave with 32-bit data, byte addresses
// Notes:   register indexes chosen as byte offsets from the block base
package uessb_pkg;

  // ==========================================
  // register map
  localparam logic [3:0] OFF_BUS_SUSPEND  = 4'h0;
  localparam logic [3:0] OFF_EP_STALL     = 4'h4;
  localparam logic [3:0] OFF_IRQ_STATUS   = 4'h8;
  localparam logic [3:0] OFF_IRQ_MASK     = 4'hC;
  localparam logic [3:0] OFF_HALT_CTRL    = 4'h0;  // unused alias guard
  // printed address of the bus status register, kept for reference by software
  localparam logic [15:0] BUS_SUSPEND_PRINTED = 16'hFF68;

  // ==========================================
  // field positions
  localparam int RESUME_BIT       = 7;
  localparam int NUM_EP           = 3;
  localparam int IRQ_RESUME_SUSPEND_EVENT_BIT   = 0;
  localparam int IRQ_ENDPOINT_STALLED_EVENT_BIT   = 1;
  localparam int NUM_IRQ          = 2;

  // ==========================================
  // reset values
  localparam logic [7:0]  BUS_SUSPEND_RST = 8'h00;
  localparam logic [2:0]  HALT_RST        = 3'h0;
  localparam logic [1:0]  IRQ_MASK_RST    = 2'h0;

  // ==========================================
  // carriers
  typedef struct packed {
    logic       setup_tok;      // setup token received, any endpoint 0
    logic [2:0] stall_cond;     // overrun or undefined request per endpoint
    logic [2:0] set_feat;       // set_feature endpoint halt
    logic [2:0] clr_feat;       // clear_feature endpoint halt
    logic       get_stat_ep0;   // get_status endpoint 0
    logic       fw_decode;      // request passed to firmware decode
    logic       cfg_done;       // set_interface or set_configuration processed
    logic [2:0] cfg_target;     // endpoints on the targeted interface
  } uessb_req_t;

  typedef struct packed {
    logic [2:0] fw_set;         // firmware sets halt feature
    logic [2:0] fw_clr;         // firmware clears halt feature
  } uessb_fw_t;

endpackage : uessb_pkg

// ### rtl/uessb_status.sv
// Purpose: bus resume/suspend status and endpoint 0..2 stall tracking
// Assumes: one 50 MHz clock, synchronous active-low reset, avalon-mm registers
// Notes:   resume detect path is combinational so it works with clk stopped
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps

// Notes on behaviour
// RL1: bus status bit 7 reads 1 when suspended, else 0; others 0; reset 0. Here a read clears bit 7 even while still suspended (RL3).
// RL2: software trusts the resume flag only after a status interrupt.
// RL3: reading the bus status register clears the resume flag.
// RL4: resume flag is sampled on clk; resume detect runs without clk.
// RL5: resume detect output stays live when clk halts to wake system.
// RL6: both status registers are read-only 8-bit; writes do nothing.
// RL7: stall bits 2..0 set by hardware on overrun or undefined request.
// RL8: stall bit undefined for endpoints not enabled by interface mapping.
// RL9: endpoint 0 stall from overrun or bad request also sets send-stall.
// RL10: next setup token clears send-stall, which clears endpoint 0 stall.
// RL11: endpoint 0 halt by set_feature holds until clear_feature or firmware.
// RL12: after ep0 status/feature or firmware request, ep0 stall reads 0 until setup.
// RL13: stall bit holds until clear_feature, set_interface/configuration, or firmware.
// RL14: processed set_interface/configuration clears halts of targeted endpoints except 0.
// RL15: endpoint 0 halt is never cleared by set_interface or set_configuration.
// RL16: software reads bus status bit 7 on a resume-or-suspend interrupt.
// RL17: endpoint-stalled event also fires when firmware stalls an endpoint.
// RL18: each stall bit follows its halt feature within one clock.
module uessb_status (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // avalon-mm slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic [31:0]               avs_readdata,
  output logic                      avs_waitrequest,
  // serial interface engine
  input  wire logic                 suspend_pin,
  input  wire logic                 resume_detect_raw,
  output logic                      resume_detect_signal,
  input  wire uessb_pkg::uessb_req_t req,
  // firmware halt control and endpoint enables
  input  wire uessb_pkg::uessb_fw_t fw,
  input  wire logic [2:0]           endpoint_interface_map,
  // status outputs
  output logic                      send_stall_control,
  output logic                      resume_suspend_event,
  output logic                      endpoint_stalled_event,
  output logic                      usb_status_irq
);
  import uessb_pkg::*;

  // ==========================================
  // resume detect passthrough, no clock needed
  assign resume_detect_signal = resume_detect_raw;  // RL4 RL5

  // ==========================================
  // suspend pin synchroniser
  logic susp_meta;
  logic susp_sync;
  logic susp_prev;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      susp_meta <= 1'b0;
      susp_sync <= 1'b0;
      susp_prev <= 1'b0;
    end else begin
      susp_meta <= suspend_pin;
      susp_sync <= susp_meta;
      susp_prev <= susp_sync;
    end
  end

  // ==========================================
  // bus decode, one cycle answer
  logic       rd_pending;
  wire        req_any       = avs_read | avs_write;
  wire        rd_accept     = avs_read & rd_pending;
  wire        sel_bus       = (avs_address == OFF_BUS_SUSPEND);
  wire        sel_stall     = (avs_address == OFF_EP_STALL);
  wire        sel_irq       = (avs_address == OFF_IRQ_STATUS);
  wire        sel_mask      = (avs_address == OFF_IRQ_MASK);
  wire        wr_mask       = avs_write & sel_mask & avs_byteenable[0];
  wire        rd_bus        = rd_accept & sel_bus;
  wire        rd_irq        = rd_accept & sel_irq;
  // writes finish at once, reads after one wait cycle
  assign avs_waitrequest = avs_read & ~rd_pending;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= avs_read & ~rd_pending;
    end
  end

  // ==========================================
  // bus resume flag
  logic bus_resume_flag;
  wire  susp_change = susp_sync ^ susp_prev;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_resume_flag <= BUS_SUSPEND_RST[RESUME_BIT];  // RL1
    end else if (susp_change) begin
      bus_resume_flag <= susp_sync;  // RL4
    end else if (rd_bus) begin
      bus_resume_flag <= 1'b0;  // RL3
    end
  end
  assign resume_suspend_event = susp_change;  // RL16

  // ==========================================
  // endpoint halt features
  logic [2:0] halt_feat;
  logic [2:0] next_halt_feat;
  logic       ep0_by_feature;
  logic       ep0_mask;
  logic       next_send_stall;
  wire  [2:0] cfg_clr    = req.cfg_done ? {req.cfg_target[2:1], 1'b0} : 3'b000;  // RL14 RL15
  wire  [2:0] hw_set     = req.stall_cond | req.set_feat | fw.fw_set;  // RL7
  wire  [2:0] any_clr    = req.clr_feat | cfg_clr | fw.fw_clr;  // RL13
  wire        ep0_status = req.get_stat_ep0 | req.set_feat[0] | req.clr_feat[0] | req.fw_decode;
  wire        setup_clr0 = req.setup_tok & send_stall_control & ~ep0_by_feature;  // RL10

  always_comb begin
    next_halt_feat = (halt_feat & ~any_clr) | hw_set;
    if (setup_clr0 && !req.stall_cond[0]) begin
      next_halt_feat[0] = 1'b0;  // RL10
    end
    next_send_stall = send_stall_control;
    if (req.stall_cond[0]) begin
      next_send_stall = 1'b1;  // RL9
    end else if (req.setup_tok) begin
      next_send_stall = 1'b0;  // RL10
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      halt_feat          <= HALT_RST;
      send_stall_control <= 1'b0;
      ep0_by_feature     <= 1'b0;
      ep0_mask           <= 1'b0;
    end else begin
      halt_feat          <= next_halt_feat;  // RL18
      send_stall_control <= next_send_stall;
      if (req.set_feat[0] | fw.fw_set[0]) begin
        ep0_by_feature <= 1'b1;  // RL11
      end else if (req.clr_feat[0] | fw.fw_clr[0]) begin
        ep0_by_feature <= 1'b0;  // RL11
      end
      if (ep0_status) begin
        ep0_mask <= 1'b1;  // RL12
      end else if (req.setup_tok) begin
        ep0_mask <= 1'b0;  // RL12
      end
    end
  end

  // disabled endpoints read 0, their value being undefined
  wire [2:0] stall_view = halt_feat & {endpoint_interface_map[2:1], 1'b1}
                          & {2'b11, ~ep0_mask};  // RL8 RL12
  assign endpoint_stalled_event = |hw_set;  // RL17

  // ==========================================
  // interrupt status, cleared by read
  logic [NUM_IRQ-1:0] irq_status;
  logic [NUM_IRQ-1:0] irq_mask;
  wire  [NUM_IRQ-1:0] irq_set = {endpoint_stalled_event, resume_suspend_event};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_status <= '0;
      irq_mask   <= IRQ_MASK_RST;
    end else begin
      irq_status <= (rd_irq ? '0 : irq_status) | irq_set;
      if (wr_mask) begin
        irq_mask <= avs_writedata[NUM_IRQ-1:0];
      end
    end
  end
  assign usb_status_irq = |(irq_status & irq_mask);

  // ==========================================
  // read data
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !rd_pending) begin
      avs_readdata <= 32'h0000_0000;
      if (sel_bus) begin
        avs_readdata[RESUME_BIT] <= bus_resume_flag;  // RL1 RL6
      end else if (sel_stall) begin
        avs_readdata[NUM_EP-1:0] <= stall_view;  // RL6 RL7
      end else if (sel_irq) begin
        avs_readdata[NUM_IRQ-1:0] <= irq_status;
      end else if (sel_mask) begin
        avs_readdata[NUM_IRQ-1:0] <= irq_mask;
      end
    end
  end

endmodule : uessb_status

// ### tb/uessb_sva.sv
// Purpose: port checks for the status block
// Assumes: one clock, sync active-low reset
// Notes:   bound into every uessb_status
`timescale 1ns/100ps
module uessb_sva (
  // clock, reset and bus
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire logic                  avs_read,
  input wire logic                  avs_write,
  input wire logic                  avs_waitrequest,
  input wire logic [31:0]           avs_readdata,
  // engine side and outputs
  input wire logic                  suspend_pin,
  input wire logic                  resume_detect_raw,
  input wire uessb_pkg::uessb_req_t req,
  input wire uessb_pkg::uessb_fw_t  fw,
  input wire logic                  resume_detect_signal,
  input wire logic                  send_stall_control,
  input wire logic                  resume_suspend_event,
  input wire logic                  endpoint_stalled_event
);
  import uessb_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rd_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");
  chk_wr_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  chk_rd_upper: assert property ($fell(avs_waitrequest) |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  chk_snd_set: assert property (req.stall_cond[0] && !req.setup_tok |=> send_stall_control)
    else $error("send stall not set");
  chk_snd_clr: assert property (req.setup_tok && !req.stall_cond[0] |=> !send_stall_control)
    else $error("send stall not cleared");
  chk_resume_live: assert property (resume_detect_signal == resume_detect_raw)
    else $error("resume detect differs");
  chk_susp_event: assert property ($changed(suspend_pin) |-> ##[1:4] resume_suspend_event)
    else $error("no bus state event");
  chk_halt_event: assert property (req.stall_cond[0] || fw.fw_set[0] |-> endpoint_stalled_event)
    else $error("no stall event");
  cov_read: cover property ($fell(avs_waitrequest));
  cov_stall: cover property (req.stall_cond[0] ##1 send_stall_control);
  cov_susp: cover property (resume_suspend_event);
endmodule : uessb_sva

bind uessb_status uessb_sva u_sva (.clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest, .avs_readdata,
  .suspend_pin, .resume_detect_raw, .req, .fw, .resume_detect_signal, .send_stall_control,
  .resume_suspend_event, .endpoint_stalled_event);

// ### tb/uessb_host.sv
// Purpose: host and engine side model
// Assumes: requests are one-clock pulses
// Notes:   bus levels hold until changed
`timescale 1ns/100ps
module uessb_host (
  // clock
  input  wire logic                  clk,
  // engine side
  output uessb_pkg::uessb_req_t      req,
  output logic                       suspend_pin,
  output logic                       resume_detect_raw
);
  import uessb_pkg::*;
  initial begin
    req = '0;
    suspend_pin = 1'b0;
    resume_detect_raw = 1'b0;
  end
  task automatic send(input uessb_req_t r);
    @(posedge clk);
    req <= r;
    @(posedge clk);
    req <= '0;
  endtask : send
  task automatic bus(input logic s);
    @(posedge clk);
    suspend_pin <= s;
    resume_detect_raw <= s;
  endtask : bus
endmodule : uessb_host

// ### tb/uessb_status_tb.sv
// Purpose: self-checking bench for the status block
// Assumes: 50 MHz clock, reset held 8 cycles
// Notes:   registers reached through avalon-mm tasks
`timescale 1ns/100ps
module uessb_status_tb;
  import uessb_pkg::*;
  logic        clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, sp, rr, rds, sst, irq, ia;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, d;
  logic        avs_waitrequest;
  logic [2:0]  map = 3'h6;
  uessb_req_t  req;
  uessb_fw_t   fw = '0;
  int          fail_count = 0, check_count = 0, cyc = 0;
  always #10 clk = ~clk;
  uessb_host host (.clk(clk), .req(req), .suspend_pin(sp), .resume_detect_raw(rr));
  uessb_status dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .suspend_pin(sp), .resume_detect_raw(rr), .resume_detect_signal(rds),
    .req(req), .fw(fw), .endpoint_interface_map(map), .send_stall_control(sst), .resume_suspend_event(),
    .endpoint_stalled_event(), .usb_status_irq(irq));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic acc(input logic [3:0] ad, input logic w, input logic [31:0] dt);
    @(posedge clk);
    avs_address <= ad;
    avs_writedata <= dt;
    avs_write <= w;
    avs_read <= !w;
    // hold the request until waitrequest is sampled low at a rising edge
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    d = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic rc(input logic [3:0] ad, input logic [31:0] exp);
    acc(ad, 1'b0, 32'h0000_0000);
    cmp(d, exp);
  endtask : rc
  task automatic fp(input uessb_fw_t f);
    @(posedge clk);
    fw <= f;
    @(posedge clk);
    fw <= '0;
  endtask : fp
  function automatic uessb_req_t mk(logic s, logic [2:0] sc, logic [2:0] sf, logic [2:0] cf, logic cd);
    mk = '0;
    {mk.setup_tok, mk.stall_cond, mk.set_feat, mk.clr_feat, mk.cfg_done, mk.cfg_target} = {s, sc, sf, cf, cd, 3'h7};
  endfunction : mk
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rc(4'h0, 32'h0000_0000);
    acc(4'h0, 1'b1, 32'h0000_00FF);
    acc(4'h4, 1'b1, 32'h0000_0007);
    rc(4'h0, 32'h0000_0000);
    rc(4'h4, 32'h0000_0000);
    rc(4'h2, 32'h0000_0000);
    $display("test registers done");
    host.bus(1'b1);
    @(negedge clk) cmp(32'(rds), 32'h0000_0001);
    repeat (5) @(posedge clk);
    rc(4'h0, 32'h0000_0080);
    rc(4'h0, 32'h0000_0000);
    acc(4'hC, 1'b1, 32'h0000_0000);
    @(negedge clk) ia = irq;
    acc(4'hC, 1'b1, 32'h0000_0003);
    @(negedge clk) cmp(32'(ia ^ irq), 32'h0000_0001);
    rc(4'h8, 32'h0000_0001);
    @(negedge clk) cmp(32'(irq), 32'h0000_0000);
    host.bus(1'b0);
    repeat (5) @(posedge clk);
    rc(4'h8, 32'h0000_0001);
    $display("test bus state done");
    host.send(mk(1'b0, 3'h1, 3'h0, 3'h0, 1'b0));
    @(negedge clk) cmp(32'(sst), 32'h0000_0001);
    rc(4'h4, 32'h0000_0001);
    host.send(mk(1'b1, 3'h0, 3'h0, 3'h0, 1'b0));
    rc(4'h4, 32'h0000_0000);
    host.send(mk(1'b0, 3'h6, 3'h1, 3'h0, 1'b0));
    rc(4'h4, 32'h0000_0006);
    host.send(mk(1'b1, 3'h0, 3'h0, 3'h0, 1'b0));
    rc(4'h4, 32'h0000_0007);
    host.send(mk(1'b0, 3'h0, 3'h0, 3'h0, 1'b1));
    rc(4'h4, 32'h0000_0001);
    host.send(mk(1'b0, 3'h0, 3'h0, 3'h1, 1'b0));
    host.send(mk(1'b1, 3'h0, 3'h0, 3'h0, 1'b0));
    rc(4'h4, 32'h0000_0000);
    $display("test stall requests done");
    fp(6'h10);
    rc(4'h4, 32'h0000_0002);
    fp(6'h02);
    rc(4'h4, 32'h0000_0000);
    map <= 3'h0;
    fp(6'h20);
    rc(4'h4, 32'h0000_0000);
    rc(4'h8, 32'h0000_0002);
    $display("test firmware halt done");
    fp(6'h08);
    host.send(16'h0010);
    rc(4'h4, 32'h0000_0000);
    host.send(16'h8000);
    rc(4'h4, 32'h0000_0001);
    host.send(16'h0020);
    rc(4'h4, 32'h0000_0000);
    host.send(16'h8000);
    rc(4'h4, 32'h0000_0001);
    $display("test status mask done");
    conclude();
  end
endmodule : uessb_status_tb
